// [inc/fpled_pkg.sv]
// Package for the front panel LED output decoder.
// Assumes a 50 MHz system clock and byte-wide I/O register writes.
package fpled_pkg;
  // I/O addresses of the two output registers.
  localparam logic [15:0] FPLED_ADDR_LOW = 16'h0435;
  localparam logic [15:0] FPLED_ADDR_HIGH = 16'h0437;
  // Field positions.
  localparam int FPLED_STATUS_LSB = 5;
  localparam int FPLED_STATUS_MSB = 6;
  localparam int FPLED_USER1_BIT = 4;
  localparam int FPLED_USER2_BIT = 0;
  // Values after reset: status pins at 00 read inverted as 11 (blinking amber).
  localparam logic [7:0] FPLED_LOW_RESET = 8'h00;
  localparam logic [7:0] FPLED_HIGH_RESET = 8'h00;
  // Blink timing: half period of a 1 Hz square wave.
  localparam int FPLED_CLK_HZ = 50000000;
  localparam int FPLED_BLINK_HALF_MS = 500;
  localparam int FPLED_BLINK_HALF_CYC = FPLED_CLK_HZ / 1000 * FPLED_BLINK_HALF_MS;
  localparam int FPLED_DIV_W = 25;
  // Decoded status codes.
  localparam logic [1:0] FPLED_CODE_GREEN = 2'h0;
  localparam logic [1:0] FPLED_CODE_GREEN_BLINK = 2'h1;
  localparam logic [1:0] FPLED_CODE_AMBER = 2'h2;
  localparam logic [1:0] FPLED_CODE_AMBER_BLINK = 2'h3;
endpackage

// [rtl/fpled_blink.sv]
// Free-running blink divider giving an equal-duty square wave.
// Assumes one clock; half period is a parameter so simulation can shorten it.
`timescale 1ns/1ns
`default_nettype none
module fpled_blink
  import fpled_pkg::*;
#(
  parameter int HALF_CYC = FPLED_BLINK_HALF_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Square wave.
  output logic blink
);
  logic [FPLED_DIV_W-1:0] count;
  logic [FPLED_DIV_W-1:0] next_count;
  logic next_blink;

  // Count to the half period, then flip the phase.
  always_comb begin
    next_count = count + 25'h1;
    next_blink = blink;
    if (count == FPLED_DIV_W'(HALF_CYC - 1)) begin
      next_count = '0;
      next_blink = ~blink;
    end
  end

  // Registers only.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      blink <= 1'b0;
    end else begin
      count <= next_count;
      blink <= next_blink;
    end
  end
endmodule
`default_nettype wire

// [rtl/fpled_decoder.sv]
// Front panel LED decoder fed by general-purpose output registers.
// Assumes a byte-wide I/O write/read port on the system clock domain.
`timescale 1ns/1ns
`default_nettype none
module fpled_decoder
  import fpled_pkg::*;
#(
  parameter int HALF_CYC = FPLED_BLINK_HALF_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // I/O register port.
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_hit,
  // Raw output pin levels.
  output logic [1:0] status_led_select_outputs,
  output logic user_led_one_output,
  output logic user_led_two_output,
  // LED drives, high lights the LED.
  output logic led_green,
  output logic led_amber,
  output logic led_user_one,
  output logic led_user_two
);
  logic [7:0] led_output_low_byte;
  logic [7:0] led_output_high_byte;
  logic [7:0] next_low;
  logic [7:0] next_high;
  logic [7:0] next_rdata;
  logic next_hit;
  logic blink;
  logic [1:0] code;
  logic next_green;
  logic next_amber;
  logic blink_seen;
  logic next_blink_seen;
  logic [FPLED_DIV_W-1:0] blink_run;
  logic [FPLED_DIV_W-1:0] next_blink_run;

  // Shared blink source for both blinking modes.
  fpled_blink #(.HALF_CYC(HALF_CYC)) u_blink (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .blink(blink)
  );

  // Register writes and read data; unmapped addresses read zero.
  always_comb begin
    next_low = led_output_low_byte;
    next_high = led_output_high_byte;
    next_rdata = 8'h00;
    next_hit = 1'b0;
    if (io_wr && io_addr == FPLED_ADDR_LOW) begin
      next_low = io_wdata;
    end
    if (io_wr && io_addr == FPLED_ADDR_HIGH) begin
      next_high = io_wdata;
    end
    if (io_rd && io_addr == FPLED_ADDR_LOW) begin
      next_rdata = led_output_low_byte;
      next_hit = 1'b1;
    end
    if (io_rd && io_addr == FPLED_ADDR_HIGH) begin
      next_rdata = led_output_high_byte;
      next_hit = 1'b1;
    end
  end

  // Pin inversion happens here: a low pin counts as a one.
  assign code = ~led_output_high_byte[FPLED_STATUS_MSB:FPLED_STATUS_LSB];

  // Decode the status code into the two front LEDs.
  always_comb begin
    next_green = 1'b0;
    next_amber = 1'b0;
    unique case (code)
      FPLED_CODE_GREEN: next_green = 1'b1;
      FPLED_CODE_GREEN_BLINK: next_green = blink;
      FPLED_CODE_AMBER: next_amber = 1'b1;
      FPLED_CODE_AMBER_BLINK: next_amber = blink;
    endcase
  end

  // All outputs are registered; reset clears every pin, giving blinking amber.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_output_low_byte <= FPLED_LOW_RESET;
      led_output_high_byte <= FPLED_HIGH_RESET;
      io_rdata <= 8'h00;
      io_hit <= 1'b0;
      status_led_select_outputs <= 2'h0;
      user_led_one_output <= 1'b0;
      user_led_two_output <= 1'b0;
      led_green <= 1'b0;
      led_amber <= 1'b0;
      led_user_one <= 1'b0;
      led_user_two <= 1'b0;
    end else begin
      led_output_low_byte <= next_low;
      led_output_high_byte <= next_high;
      io_rdata <= next_rdata;
      io_hit <= next_hit;
      status_led_select_outputs <= led_output_high_byte[FPLED_STATUS_MSB:FPLED_STATUS_LSB];
      user_led_one_output <= led_output_high_byte[FPLED_USER1_BIT];
      user_led_two_output <= led_output_low_byte[FPLED_USER2_BIT];
      led_green <= next_green;
      led_amber <= next_amber;
      led_user_one <= led_output_high_byte[FPLED_USER1_BIT];
      led_user_two <= led_output_low_byte[FPLED_USER2_BIT];
    end
  end

  // Helper state for the blink checks: the level seen one cycle ago and how
  // many sampled cycles the current level has lasted. It is kept apart from
  // the divider so that a miscounting divider cannot vouch for itself.
  always_comb begin
    next_blink_seen = blink;
    next_blink_run = blink_run + 25'h1;
    if (blink != blink_seen) begin
      next_blink_run = 25'h1;
    end
  end

  // Helper registers only; cleared with the divider so both start in step.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_seen <= 1'b0;
      blink_run <= '0;
    end else begin
      blink_seen <= next_blink_seen;
      blink_run <= next_blink_run;
    end
  end

  // Front LED checks; pin values are raw, so the inversion is checked too.
  // Green and amber never light together.
  AST_EXCLUSIVE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(led_green && led_amber))
    else $error("Green and amber lit together.");
  // Steady green follows a pin pair of 11.
  AST_STEADY_GREEN: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (led_output_high_byte[FPLED_STATUS_MSB:FPLED_STATUS_LSB] == 2'h3)
    |=> led_green && !led_amber)
    else $error("Steady green missing.");
  // Steady amber follows a pin pair of 01.
  AST_STEADY_AMBER: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (led_output_high_byte[FPLED_STATUS_MSB:FPLED_STATUS_LSB] == 2'h1)
    |=> led_amber && !led_green)
    else $error("Steady amber missing.");
  // Blinking amber tracks the divider; this is also the reset state.
  AST_BLINK_AMBER: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (led_output_high_byte[FPLED_STATUS_MSB:FPLED_STATUS_LSB] == 2'h0)
    |=> (led_amber == $past(blink)) && !led_green)
    else $error("Blinking amber wrong.");
  // Blinking green tracks the divider.
  AST_BLINK_GREEN: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (led_output_high_byte[FPLED_STATUS_MSB:FPLED_STATUS_LSB] == 2'h2)
    |=> (led_green == $past(blink)) && !led_amber)
    else $error("Blinking green wrong.");

  // Register path checks.
  // A write to the high byte reaches user LED one two cycles later.
  AST_USER_ONE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (io_wr && io_addr == FPLED_ADDR_HIGH)
    |=> ##1 led_user_one == $past(io_wdata[FPLED_USER1_BIT], 2))
    else $error("User LED one wrong.");
  // A write to the low byte reaches user LED two two cycles later.
  AST_USER_TWO: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (io_wr && io_addr == FPLED_ADDR_LOW)
    |=> ##1 led_user_two == $past(io_wdata[FPLED_USER2_BIT], 2))
    else $error("User LED two wrong.");
  // A read of the high byte returns the stored byte next cycle.
  AST_READBACK: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (io_rd && !io_wr && io_addr == FPLED_ADDR_HIGH)
    |=> io_hit && (io_rdata == $past(led_output_high_byte)))
    else $error("Readback wrong.");
  // A read of the low byte returns the stored byte next cycle.
  AST_READBACK_LOW: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (io_rd && io_addr == FPLED_ADDR_LOW)
    |=> io_hit && (io_rdata == $past(led_output_low_byte)))
    else $error("Low byte readback wrong.");
  // Without a read strobe the answer port rests at zero.
  AST_RDATA_IDLE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !io_rd |=> (io_rdata == 8'h00) && !io_hit)
    else $error("Read port not idle.");
  // Writes to unmapped addresses leave both bytes alone.
  AST_UNMAPPED_WRITE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (io_wr && io_addr != FPLED_ADDR_LOW && io_addr != FPLED_ADDR_HIGH)
    |=> $stable(led_output_low_byte) && $stable(led_output_high_byte))
    else $error("Unmapped write changed a register.");
  // The raw status pins mirror the stored field one cycle later.
  AST_PIN_MIRROR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    status_led_select_outputs ==
    $past(led_output_high_byte[FPLED_STATUS_MSB:FPLED_STATUS_LSB]))
    else $error("Status pins wrong.");
  // The raw user pins mirror their stored bits one cycle later.
  AST_USER_PINS: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    {user_led_one_output, user_led_two_output} ==
    $past({led_output_high_byte[FPLED_USER1_BIT], led_output_low_byte[FPLED_USER2_BIT]}))
    else $error("User pins wrong.");
  // Held reset leaves both user LEDs and their pins dark.
  AST_RESET_CLEAR: assert property (
    @(posedge sys_clk)
    !rst_n |=> !led_user_one && !led_user_two &&
    !user_led_one_output && !user_led_two_output)
    else $error("User LEDs not cleared by reset.");

  // Divider checks.
  // A high phase lasts at least nine sampled cycles.
  AST_BLINK_HOLD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(blink) |=> blink [*8])
    else $error("Blink too short.");
  // A low phase lasts at least nine sampled cycles.
  AST_BLINK_LOW_HOLD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(blink) |=> !blink [*8])
    else $error("Blink low phase too short.");
  // Each phase ends after exactly the half period, giving equal duty.
  AST_BLINK_PERIOD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (blink != blink_seen) |-> (blink_run == FPLED_DIV_W'(HALF_CYC)))
    else $error("Blink phase length wrong.");
  // No phase outlasts the half period.
  AST_BLINK_RUN: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    blink_run <= FPLED_DIV_W'(HALF_CYC))
    else $error("Blink phase too long.");
endmodule
`default_nettype wire

// [tb/fpled_host_model.sv]
// Host model: issues byte I/O writes and reads as firmware would.
// Assumes the decoder samples its strobes on rising sys_clk.
`timescale 1ns/1ns
`default_nettype none
module fpled_host_model (
  // Clock and answer.
  input wire logic sys_clk,
  input wire logic [7:0] io_rdata,
  input wire logic io_hit,
  // Request.
  output logic io_wr,
  output logic io_rd,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata
);
  // Idle levels from time zero.
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  // One-cycle write strobe, held across its sampling edge.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
    @(posedge sys_clk);
    #1;
    io_wr = 1'b0;
    io_wdata = ~d; // Stale data is scrambled so a late capture shows.
  endtask
  // Read; the registered answer is taken one cycle after the strobe.
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic h);
    @(posedge sys_clk);
    #1;
    io_rd = 1'b1;
    io_addr = a;
    @(posedge sys_clk);
    #1;
    io_rd = 1'b0;
    d = io_rdata;
    h = io_hit;
  endtask
endmodule
`default_nettype wire

// [tb/fpled_decoder_tb.sv]
// Testbench for the LED decoder: status codes, user LEDs, reset state.
// Assumes the host model in tb/ and a short blink half period.
`timescale 1ns/1ns
`default_nettype none
module fpled_decoder_tb;
  import fpled_pkg::*;
  localparam int H = 10;
  localparam logic [7:0] B = 8'(H);
  localparam logic [7:0] F = 8'(2 * H);
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic io_wr, io_rd, io_hit, hit, u1, u2, lg, la, l1, l2;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, d, g, a;
  logic [1:0] sel;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  `define CHK(x, e) begin num_checks++; if ((x) !== (e)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, x, e); end end
  always #10 sys_clk = ~sys_clk;
  fpled_host_model i_fpled_host_model (.sys_clk(sys_clk), .io_rdata(io_rdata),
    .io_hit(io_hit), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata));
  fpled_decoder #(.HALF_CYC(H)) i_fpled_decoder (.sys_clk(sys_clk), .rst_n(rst_n),
    .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_hit(io_hit), .status_led_select_outputs(sel),
    .user_led_one_output(u1), .user_led_two_output(u2), .led_green(lg),
    .led_amber(la), .led_user_one(l1), .led_user_two(l2));
  // Counts lit cycles over one blink period; a square wave gives exactly H.
  task automatic obs();
    g = 8'h00;
    a = 8'h00;
    repeat (2 * H) begin
      @(posedge sys_clk);
      #1;
      g = g + {7'h00, lg};
      a = a + {7'h00, la};
    end
  endtask
  // Writes a logical status code (pins inverted) and user LED one.
  task automatic st(input logic [1:0] c, input logic u);
    i_fpled_host_model.wr(FPLED_ADDR_HIGH, {1'b0, ~c, u, 4'h0});
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK({sel, u1, l1}, {~c, u, u})
    obs();
    `CHK(g, (c == 2'h0) ? F : (c == 2'h1) ? B : 8'h00)
    `CHK(a, (c == 2'h2) ? F : (c == 2'h3) ? B : 8'h00)
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Cuts a hang short; the tests need under two hundred cycles.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      complete_run();
    end
  end
  // Main sequence.
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    `CHK({l1, l2, u1, u2}, 4'h0)
    repeat (4) @(posedge sys_clk);
    obs();
    `CHK({g, a}, {8'h00, B})
    i_fpled_host_model.rd(FPLED_ADDR_LOW, d, hit);
    `CHK({d, hit}, 9'h001)
    i_fpled_host_model.rd(16'h0436, d, hit);
    `CHK({d, hit}, 9'h000)
    $display("test reset done");
    for (int i = 0; i < 4; i++) st(2'(i), i[0]);
    st(2'h0, 1'b1);
    $display("test status done");
    i_fpled_host_model.wr(FPLED_ADDR_LOW, 8'h01);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK({u2, l2, l1}, 3'h7)
    i_fpled_host_model.rd(FPLED_ADDR_LOW, d, hit);
    `CHK({d, hit}, 9'h003)
    i_fpled_host_model.wr(FPLED_ADDR_LOW, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK({l2, l1}, 2'h1)
    i_fpled_host_model.wr(16'h0436, 8'hff);
    i_fpled_host_model.rd(FPLED_ADDR_HIGH, d, hit);
    `CHK({d, hit, lg, l2}, 11'h386)
    $display("test user done");
    complete_run();
  end
endmodule
`default_nettype wire
